// file: core/adcsq_control.sv
// adcsq_control: register file, freeze and sequence start logic of the converter
//
// Functional notes
// (RULE1) freeze register write aborts running sequence
// (RULE2) freeze field selects debug response
// (RULE3) prescale write aborts, halts until start write
// (RULE4) resolution bit selects 8 or 10 bits
// (RULE5) sample field sets 2/4/8/16 final periods
// (RULE6) prescaler divides by value+1, then two
// (RULE7) zero prescale acts as one
// (RULE8) reset prescale gives divide by four
// (RULE9) software keeps converter clock 500k-2M; the testbench runs it above 2M with its 8 ns bus clock
// (RULE10) start register write begins new sequence
// (RULE11) start write aborts and clears all flags
// (RULE12) length bit selects four or eight
// (RULE13) repeat bit selects single or continuous
// (RULE14) walk clear converts one selected channel
// (RULE15) walk set converts consecutive group channels
// (RULE16) done flag on first sequence finish
// (RULE17) result flag set until result read
// (RULE18) software gives all four channel bits
// (RULE19) software uses prescale codes up to seven
// (RULE20) reserved freeze code keeps converting
`timescale 1ns/1ps
module adcsq_control
  import adcsq_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // debug and result side
  input wire logic halt_debug_state,
  input wire logic [CHANNELS-1:0] result_read,
  // converter core side
  output logic conv_start,
  output logic conv_active,
  output logic [3:0] conv_channel,
  output logic [2:0] conv_slot,
  output logic resolution_select,
  output logic conv_done,
  output logic sequence_done_flag,
  output logic [CHANNELS-1:0] result_ready_flag
);

  initial begin
    if (CHANNELS != 8) $error("sequencer serves exactly eight result slots");
  end

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    adcsq_state_type st;          // sequencer state
    logic [7:0] frz_reg;          // debug_freeze_control
    logic [7:0] prs_reg;          // clock_prescale_control
    logic [7:0] seq_reg;          // sequence_start_control
    logic [5:0] period_cnt;       // converter periods left in this conversion
    logic [2:0] slot;             // result slot being converted
    logic seq_seen;               // a sequence already completed
    logic done_flag;              // sequence_done_flag
    logic [7:0] ready;            // result_ready_flag vector
    logic start_pulse;            // conversion start strobe
    logic done_pulse;             // conversion end strobe
    logic [3:0] chan;             // channel of current conversion
    logic [7:0] rdata;            // read data, one cycle after strobe
    logic dbg_meta;               // debug synchroniser stage one
    logic dbg_sync;               // debug synchroniser stage two
  } adcsq_ctl_type;

  adcsq_ctl_type cur;
  adcsq_ctl_type next_cur;
  logic conv_tick;
  logic pre_restart;
  logic frozen;
  logic last_slot;
  logic [5:0] conv_len;

  // ***************************************************
  // helpers
  // ***************************************************
  // final sample periods for a sample code
  function automatic logic [5:0] sample_periods(input logic [1:0] code);
    sample_periods = 6'(6'h02 << code); // see (RULE5)
  endfunction : sample_periods

  // full conversion length in converter periods
  function automatic logic [5:0] total_periods(input logic [7:0] prs);
    total_periods = sample_periods(prs[SMP_HI_POS:SMP_LO_POS])
      + (prs[RES_POS] ? BASE_10BIT : BASE_8BIT); // see (RULE4) see (RULE5)
  endfunction : total_periods

  // channel for a slot, single or walking
  function automatic logic [3:0] slot_channel(input logic [7:0] seq, input logic [2:0] s);
    logic [3:0] base;
    base = seq[CHAN_POS+3:CHAN_POS];
    if (!seq[WALK_POS]) begin
      slot_channel = base; // see (RULE14) see (RULE18)
    end else if (seq[LEN_POS]) begin
      slot_channel = {base[3], s}; // see (RULE15)
    end else begin
      slot_channel = {base[3:2], s[1:0]}; // see (RULE15)
    end
  endfunction : slot_channel

  // ***************************************************
  // converter clock
  // ***************************************************
  // restart the prescaler when its setting changes so the first period is whole
  assign pre_restart = reg_wr && (reg_addr == ADDR_CLOCK_PRESCALE);

  adcsq_prescaler #(
    .PRS_W(5)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .prescale_value(cur.prs_reg[PRS_POS+4:PRS_POS]), // see (RULE6)
    .restart(pre_restart),
    .conv_tick(conv_tick)
  );

  // ***************************************************
  // freeze decision
  // ***************************************************
  // code 11 stops at once; code 10 lets the running conversion end first;
  // reserved 01 behaves as 00 so debug has no surprise effect
  always_comb begin
    case (cur.frz_reg[FRZ_HI_POS:FRZ_LO_POS])
      FRZ_NOW: frozen = cur.dbg_sync; // see (RULE2)
      FRZ_FINISH: frozen = cur.dbg_sync && (cur.period_cnt == conv_len); // see (RULE2)
      FRZ_RESV: frozen = 1'b0; // see (RULE20)
      default: frozen = 1'b0; // see (RULE2)
    endcase
  end

  assign conv_len = total_periods(cur.prs_reg);
  assign last_slot = cur.seq_reg[LEN_POS] ? (cur.slot == 3'h7) : (cur.slot == 3'h3); // see (RULE12)

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    next_cur = cur;
    next_cur.start_pulse = 1'b0;
    next_cur.done_pulse = 1'b0;
    // debug level passes two flops before use
    next_cur.dbg_meta = halt_debug_state;
    next_cur.dbg_sync = cur.dbg_meta;

    // sequencer
    case (cur.st)
      ST_CONV: begin
        if (conv_tick && !frozen) begin
          if (cur.period_cnt <= 6'h01) begin
            // conversion ends, result slot marked
            next_cur.done_pulse = 1'b1;
            next_cur.ready[cur.slot] = 1'b1; // see (RULE17)
            next_cur.period_cnt = conv_len;
            if (last_slot) begin
              if (!cur.seq_seen) begin
                next_cur.done_flag = 1'b1; // see (RULE16)
              end
              next_cur.seq_seen = 1'b1;
              next_cur.slot = 3'h0;
              if (cur.seq_reg[REPEAT_POS]) begin
                next_cur.start_pulse = 1'b1; // see (RULE13)
                next_cur.chan = slot_channel(cur.seq_reg, 3'h0);
              end else begin
                next_cur.st = ST_IDLE; // see (RULE13)
              end
            end else begin
              next_cur.slot = cur.slot + 3'h1;
              next_cur.start_pulse = 1'b1;
              next_cur.chan = slot_channel(cur.seq_reg, cur.slot + 3'h1);
            end
          end else begin
            next_cur.period_cnt = cur.period_cnt - 6'h01;
          end
        end
      end
      ST_IDLE: begin
        // nothing running
      end
      ST_HALT: begin
        // waits only for a start write
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase

    // result reads clear their flags; a completion in the same cycle wins
    for (int i = 0; i < CHANNELS; i++) begin
      if (result_read[i] && !(next_cur.done_pulse && cur.slot == 3'(i))) begin
        next_cur.ready[i] = 1'b0; // see (RULE17)
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_DEBUG_FREEZE: begin
          next_cur.frz_reg = reg_wdata;
          if (cur.st == ST_CONV) begin
            next_cur.st = ST_IDLE; // see (RULE1)
          end
        end
        ADDR_CLOCK_PRESCALE: begin
          next_cur.prs_reg = reg_wdata;
          if (cur.st == ST_CONV) begin
            next_cur.st = ST_HALT; // see (RULE3)
          end
        end
        ADDR_SEQUENCE_START: begin
          // abort anything running and start afresh
          next_cur.seq_reg = reg_wdata;
          next_cur.st = ST_CONV; // see (RULE10) see (RULE3)
          next_cur.slot = 3'h0;
          next_cur.seq_seen = 1'b0;
          next_cur.done_flag = 1'b0; // see (RULE11)
          next_cur.ready = '0; // see (RULE11)
          next_cur.period_cnt = conv_len;
          next_cur.start_pulse = 1'b1;
          next_cur.done_pulse = 1'b0;
          next_cur.chan = slot_channel(reg_wdata, 3'h0);
        end
        default: begin
          // unmapped or read-only address: write ignored
        end
      endcase
    end

    // read data stands in the cycle after the strobe only
    next_cur.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_DEBUG_FREEZE: next_cur.rdata = cur.frz_reg;
        ADDR_CLOCK_PRESCALE: next_cur.rdata = cur.prs_reg;
        ADDR_SEQUENCE_START: next_cur.rdata = cur.seq_reg;
        ADDR_STATUS: next_cur.rdata = {cur.done_flag, 1'b0, cur.st == ST_HALT,
          cur.st == ST_CONV, 1'b0, cur.slot};
        ADDR_FLAGS: next_cur.rdata = cur.ready;
        default: next_cur.rdata = 8'h00;
      endcase
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.st <= ST_IDLE;
      cur.frz_reg <= RST_DEBUG_FREEZE;
      cur.prs_reg <= RST_CLOCK_PRESCALE; // see (RULE8)
      cur.seq_reg <= RST_SEQUENCE_START;
    end else begin
      cur <= next_cur;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign reg_rdata = cur.rdata;
  assign conv_start = cur.start_pulse;
  assign conv_active = (cur.st == ST_CONV);
  assign conv_channel = cur.chan;
  assign conv_slot = cur.slot;
  assign resolution_select = cur.prs_reg[RES_POS]; // see (RULE4)
  assign conv_done = cur.done_pulse;
  assign sequence_done_flag = cur.done_flag;
  assign result_ready_flag = cur.ready;

endmodule : adcsq_control

// file: core/adcsq_pkg.sv
// adcsq_pkg: constants and types shared by the converter sequencer control files
package adcsq_pkg;

  // ***************************************************
  // register map (index on the plain register port)
  // ***************************************************
  localparam logic [3:0] ADDR_DEBUG_FREEZE = 4'h3;   // debug_freeze_control
  localparam logic [3:0] ADDR_CLOCK_PRESCALE = 4'h4; // clock_prescale_control
  localparam logic [3:0] ADDR_SEQUENCE_START = 4'h5; // sequence_start_control
  localparam logic [3:0] ADDR_STATUS = 4'h6;         // sequence state readback
  localparam logic [3:0] ADDR_FLAGS = 4'h7;          // result_ready_flag vector

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int FRZ_LO_POS = 0;      // freeze_sel_lo
  localparam int FRZ_HI_POS = 1;      // freeze_sel_hi
  localparam int PRS_POS = 0;         // prescale_value low bit
  localparam int SMP_LO_POS = 5;      // sample_time_lo
  localparam int SMP_HI_POS = 6;      // sample_time_hi
  localparam int RES_POS = 7;         // resolution_select
  localparam int CHAN_POS = 0;        // chan_sel_0..3
  localparam int WALK_POS = 4;        // channel_walk_enable
  localparam int REPEAT_POS = 5;      // repeat bit
  localparam int LEN_POS = 6;         // sequence_length_select

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [7:0] RST_DEBUG_FREEZE = 8'h00;
  localparam logic [7:0] RST_CLOCK_PRESCALE = 8'h01; // total divide by four
  localparam logic [7:0] RST_SEQUENCE_START = 8'h00;

  // ***************************************************
  // freeze codes and timing
  // ***************************************************
  localparam logic [1:0] FRZ_RUN = 2'h0;
  localparam logic [1:0] FRZ_RESV = 2'h1;
  localparam logic [1:0] FRZ_FINISH = 2'h2;
  localparam logic [1:0] FRZ_NOW = 2'h3;
  localparam logic [5:0] BASE_8BIT = 6'h10;  // periods beyond sample, 8-bit
  localparam logic [5:0] BASE_10BIT = 6'h12; // periods beyond sample, 10-bit

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_HALT = 3'b100
  } adcsq_state_type;

endpackage : adcsq_pkg

// file: core/adcsq_prescaler.sv
// adcsq_prescaler: modulo prescaler plus divide-by-two converter clock enable
`timescale 1ns/1ps
module adcsq_prescaler
  import adcsq_pkg::*;
#(
  parameter int PRS_W = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic [PRS_W-1:0] prescale_value,
  input wire logic restart,
  // output
  output logic conv_tick
);

  initial begin
    if (PRS_W < 1 || PRS_W > 8) $error("prescaler width out of range");
  end

  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [PRS_W-1:0] count; // modulo counter
    logic half;              // divide-by-two stage
    logic tick;              // one pulse per converter clock period
  } adcsq_pre_type;

  adcsq_pre_type cur;
  adcsq_pre_type next_cur;
  logic [PRS_W-1:0] modulus;

  // zero code acts as one
  assign modulus = (prescale_value == '0) ? PRS_W'(1) : prescale_value; // see (RULE7)

  // divide by modulus+1, then by two
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (restart) begin
      next_cur.count = '0;
      next_cur.half = 1'b0;
    end else if (cur.count >= modulus) begin // see (RULE6)
      next_cur.count = '0;
      next_cur.half = ~cur.half;
      next_cur.tick = cur.half; // one tick per full symmetric period
    end else begin
      next_cur.count = cur.count + PRS_W'(1);
    end
  end

  // register the state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign conv_tick = cur.tick;

endmodule : adcsq_prescaler

// file: dv/adcsq_control_sva.sv
// adcsq_control_sva: port-level timing checker for the sequencer control block
`timescale 1ns/1ps
module adcsq_ctl_sva
  import adcsq_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // debug and result side
  input wire logic halt_debug_state,
  input wire logic [CHANNELS-1:0] result_read,
  // converter side
  input wire logic conv_start,
  input wire logic conv_active,
  input wire logic [3:0] conv_channel,
  input wire logic [2:0] conv_slot,
  input wire logic resolution_select,
  input wire logic conv_done,
  input wire logic sequence_done_flag,
  input wire logic [CHANNELS-1:0] result_ready_flag
);
  // ************
  // shadow state
  // ************
  wire wr_frz = reg_wr && reg_addr == ADDR_DEBUG_FREEZE; // freeze register write
  wire wr_prs = reg_wr && reg_addr == ADDR_CLOCK_PRESCALE; // prescale register write
  wire wr_seq = reg_wr && reg_addr == ADDR_SEQUENCE_START; // start register write
  logic [1:0] sh_frz; // freeze code in force
  logic [7:0] sh_prs; // prescale register copy
  logic [7:0] sh_seq; // start register copy
  logic [11:0] gap; // cycles since last conversion start
  logic [1:0] arm; // first gap after a disturbance may be off-phase, so it is skipped
  logic [3:0] dones; // conversions ended since the start write
  wire [3:0] walk_ch = sh_seq[LEN_POS] ? {sh_seq[3], conv_slot} : {sh_seq[3:2], conv_slot[1:0]};

  // spacing of conversions in bus clocks for a prescale setting
  function automatic int exp_gap(input logic [7:0] p);
    int n;
    n = (p[4:0] == 5'h00) ? 1 : int'(p[4:0]);
    return ((2 << p[SMP_HI_POS:SMP_LO_POS]) + (p[RES_POS] ? int'(BASE_10BIT) : int'(BASE_8BIT))) * 2 * (n + 1);
  endfunction : exp_gap

  // shadow registers and counters
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sh_frz <= 2'h0;
      sh_prs <= RST_CLOCK_PRESCALE;
      sh_seq <= RST_SEQUENCE_START;
      gap <= 12'h000;
      arm <= 2'h0;
      dones <= 4'h0;
    end else begin
      if (wr_frz) sh_frz <= reg_wdata[FRZ_HI_POS:FRZ_LO_POS];
      if (wr_prs) sh_prs <= reg_wdata;
      if (wr_seq) sh_seq <= reg_wdata;
      gap <= conv_start ? 12'h001 : gap + 12'h001;
      if (reg_wr || halt_debug_state) arm <= 2'h0;
      else if (conv_start && arm != 2'h2) arm <= arm + 2'h1;
      dones <= wr_seq ? 4'h0 : dones + 4'(conv_done);
    end
  end

  // ************
  // assertions
  // ************
  start_clean_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_seq |=> conv_start && conv_active && !sequence_done_flag && result_ready_flag == '0)
    else $error("start write did not open a clean sequence");
  freeze_abort_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_frz |=> !conv_active) else $error("freeze write left the sequence running");
  prescale_halt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_prs && conv_active |=> !conv_active) else $error("prescale write left conversion running");
  only_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(conv_active) && !sh_frz[FRZ_HI_POS] |-> $past(wr_seq)) else $error("activity began unasked");
  res_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_prs |=> resolution_select == sh_prs[RES_POS]) else $error("resolution does not follow register");
  conv_gap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    conv_start && arm == 2'h2 |-> gap == exp_gap(sh_prs)) else $error("conversion spacing wrong");
  flag_rise_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (result_ready_flag & ~$past(result_ready_flag)) != '0 |-> conv_done) else $error("flag set unasked");
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !reg_wr |=> ($past(result_ready_flag) & ~$past(result_read) & ~$past(result_read, 2) & ~result_ready_flag) == '0)
    else $error("ready flag dropped without a read");
  seq_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(sequence_done_flag) |-> dones + 4'(conv_done) == (sh_seq[LEN_POS] ? 4'h8 : 4'h4))
    else $error("sequence length wrong");
  seq_end_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(sequence_done_flag) |-> ##2 conv_active == sh_seq[REPEAT_POS]) else $error("repeat handling wrong");
  chan_pick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    conv_start |-> conv_channel == (sh_seq[WALK_POS] ? walk_ch : sh_seq[3:0])) else $error("wrong channel");
  freeze_now_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sh_frz == FRZ_NOW && halt_debug_state [*5] |-> !conv_start && !conv_done) else $error("no freeze in debug");
endmodule : adcsq_ctl_sva

bind adcsq_control adcsq_ctl_sva #(.CHANNELS(CHANNELS)) u_sva (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .halt_debug_state(halt_debug_state), .result_read(result_read), .conv_start(conv_start),
  .conv_active(conv_active), .conv_channel(conv_channel), .conv_slot(conv_slot),
  .resolution_select(resolution_select), .conv_done(conv_done), .sequence_done_flag(sequence_done_flag),
  .result_ready_flag(result_ready_flag)
);

// file: dv/tb_adc_sequencer_control.sv
// tb_adc_sequencer_control: register-driven tests of the sequencer control block
`timescale 1ns/1ps
module tb_adc_sequencer_control
  import adcsq_pkg::*;
;
  // ************
  // signals
  // ************
  logic clk_sys, nrst, reg_wr, reg_rd, halt_debug_state; // bench-driven controls
  logic [3:0] reg_addr, conv_channel;
  logic [7:0] reg_wdata, result_read, reg_rdata, result_ready_flag;
  logic conv_start, conv_active, resolution_select, conv_done, sequence_done_flag;
  logic [2:0] conv_slot;
  int num_errors, tests_run, n;
  int cyc = 0; // cycle count for the hang limit
  // prescale codes stay at seven or below; with the 8 ns bus clock the converter clock sits above the 500k-2M range
  logic [7:0] prs_tab [4] = '{8'h00, 8'h22, 8'hE3, 8'h47};
  // single-channel entries give all four channel bits
  logic [7:0] seq_tab [4] = '{8'h03, 8'h16, 8'h5F, 8'h42};
  int frz_done [4] = '{4, 4, 1, 0}; // conversions that end while debug is held

  // free-running bus clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  adcsq_control uut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_debug_state(halt_debug_state), .result_read(result_read),
    .conv_start(conv_start), .conv_active(conv_active), .conv_channel(conv_channel), .conv_slot(conv_slot),
    .resolution_select(resolution_select), .conv_done(conv_done), .sequence_done_flag(sequence_done_flag),
    .result_ready_flag(result_ready_flag)
  );

  // ************
  // tasks
  // ************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle write; returns just after the sampling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rdchk

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : idle

  // start a sequence, follow it to its done flag, check count, channels and flags
  task automatic run_seq(input logic [7:0] c);
    int s;
    int k;
    s = 0;
    k = 0;
    n = 0;
    wr(ADDR_SEQUENCE_START, c);
    chk("clean start", 10'h200, {conv_start, sequence_done_flag, result_ready_flag});
    while (sequence_done_flag !== 1'b1 && k < 4000) begin
      if (conv_start === 1'b1) begin
        // expected channel: fixed, or the slot within the selected group
        chk("channel", !c[WALK_POS] ? c[3:0] : c[LEN_POS] ? {c[3], 3'(s)} : {c[3:2], 2'(s)},
            conv_channel);
        s++;
      end
      n += int'(conv_done === 1'b1);
      k++;
      idle(1);
    end
    n += int'(conv_done === 1'b1);
    chk("conversions", c[LEN_POS] ? 8 : 4, n);
    chk("ready flags", c[LEN_POS] ? 8'hFF : 8'h0F, result_ready_flag);
    idle(2);
    chk("active after sequence", c[REPEAT_POS], conv_active);
  endtask : run_seq

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // hang limit, well above the roughly ten thousand cycles of the run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end

  // ************
  // main sequence
  // ************
  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, halt_debug_state} = 3'b000;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    result_read = 8'h00;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk("freeze reset", ADDR_DEBUG_FREEZE, RST_DEBUG_FREEZE);
    rdchk("prescale reset", ADDR_CLOCK_PRESCALE, 8'h01);
    rdchk("start reset", ADDR_SEQUENCE_START, 8'h00);
    wr(4'hF, 8'hA5);
    rdchk("unmapped", 4'hF, 8'h00);
    wr(ADDR_DEBUG_FREEZE, 8'h02);
    rdchk("freeze rw", ADDR_DEBUG_FREEZE, 8'h02);
    wr(ADDR_DEBUG_FREEZE, 8'h00);
    run_seq(8'h00);
    // divider, sample and width mixes with each channel mode
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CLOCK_PRESCALE, prs_tab[i]);
      chk("resolution", prs_tab[i][RES_POS], resolution_select);
      run_seq(seq_tab[i]);
    end
    // one result read clears only its own flag
    @(posedge clk_sys);
    result_read <= 8'h04;
    @(posedge clk_sys);
    result_read <= 8'h00;
    idle(3);
    rdchk("flags after read", ADDR_FLAGS, 8'hFB);
    wr(ADDR_CLOCK_PRESCALE, 8'h01);
    run_seq(8'h20);
    run_seq(8'h00);
    // aborts in mid-conversion
    wr(ADDR_SEQUENCE_START, 8'h00);
    idle(20);
    wr(ADDR_DEBUG_FREEZE, 8'h00);
    chk("abort by freeze write", 1'b0, conv_active);
    wr(ADDR_SEQUENCE_START, 8'h00);
    idle(20);
    wr(ADDR_CLOCK_PRESCALE, 8'h01);
    idle(300);
    chk("halt after prescale write", 2'b00, {conv_active, conv_start});
    rdchk("status halted", ADDR_STATUS, 8'h20);
    run_seq(8'h00);
    // every freeze code with debug raised just after the first start
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_DEBUG_FREEZE, 8'(f));
      wr(ADDR_SEQUENCE_START, 8'h00);
      // let the first conversion take at least one converter period before debug
      repeat (8) @(posedge clk_sys);
      halt_debug_state <= 1'b1;
      n = 0;
      repeat (400) begin
        idle(1);
        n += int'(conv_done === 1'b1);
      end
      chk("conversions in debug", frz_done[f], n);
      @(posedge clk_sys);
      halt_debug_state <= 1'b0;
    end
    results();
  end
endmodule : tb_adc_sequencer_control
